/* File: hdl/msirq_status.sv */
// status, automodem status and interrupt reporting for the modem
// Function
// - masked receive events set irq; status read clears
// - interrupt pin low when irq and enable
// - ready and overflow bits cleared by data read
// - mode change status effects within 150 us
// - ring bit works in powersave and reset
// - ring bit is inverse of ring pin
// - ring irq on pin fall, control bits 5,6
// - fsk demod bit refreshed at eight-times strobe
// - dtmf burst sets bit5, loads code
// - dtmf code maps to keypad symbol
// - automodem word: message, zeros, snr, mode
// - event message codes under upper bits 010
// - bit-rate code table
// - message update or field change sets bit9
// - automodem word read clears bit9
module msirq_status #(
  parameter int SETTLE_CYC = msirq_pkg::MODE_SETTLE_CYC // mode change settle bound
) (
  input wire logic CORE_CLK, // core clock 100 MHz
  input wire logic RESET, // synchronous reset, high
  input wire logic [15:0] GCR_WORD, // general control register value
  input wire logic POWERSAVE, // powersave mode level
  input wire msirq_pkg::msirq_rxmode_t RX_MODE, // receive operating mode
  input wire logic PROG_FLAG, // programming flag from elsewhere
  input wire msirq_pkg::msirq_rx_evt_t RX_EVT, // receive path events
  input wire msirq_pkg::msirq_am_t AM_IN, // automodem reports
  input wire logic STATUS_RD, // status word read pulse
  input wire logic RXDATA_RD, // receive data read pulse
  input wire logic AM_RD, // automodem word read pulse
  input wire logic RING_SENSE_IN_LOW, // ring sense pin, async
  output logic [15:0] STATUS_WORD, // main status word
  output logic [15:0] AM_STATUS_WORD, // automodem status word
  output logic [7:0] DTMF_KEY, // ascii of last keypad symbol
  output logic HOST_INTERRUPT_OUT_LOW, // interrupt pin value, low active
  output logic HOST_INTERRUPT_OE // interrupt pin drive enable
);
  import msirq_pkg::*;

  // ---------------------------------------------------------------
  // mode and control decode
  // ---------------------------------------------------------------
  msirq_rxmode_t mode_q;
  logic hold;
  logic hold_q;
  logic hold_rise;
  logic quiet;
  logic mode_chg;
  logic fsk_mode;
  logic qam_mode;
  logic dtmf_mode;
  logic modem_mode;
  logic ring_level;
  logic ring_rise;

  assign hold = GCR_WORD[GC_RESET] | GCR_WORD[GC_GEN_RST];
  assign hold_rise = hold & ~hold_q;
  assign quiet = hold | POWERSAVE;
  assign mode_chg = RX_MODE != mode_q;
  assign fsk_mode = RX_MODE == RXM_FSK;
  assign qam_mode = RX_MODE == RXM_QAM;
  assign dtmf_mode = RX_MODE == RXM_DTMF;
  assign modem_mode = fsk_mode | qam_mode;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      mode_q <= RXM_IDLE;
      hold_q <= 1'b0;
    end else begin
      mode_q <= RX_MODE;
      hold_q <= hold;
    end
  end

  // ring path stays on clock and sync only, independent of hold and powersave
  msirq_ring_sense u_ring (
    .clk(CORE_CLK),
    .rst(RESET),
    .pin_low(RING_SENSE_IN_LOW),
    .ring_level(ring_level),
    .ring_rise(ring_rise)
  );

  // ---------------------------------------------------------------
  // receive event bits
  // ---------------------------------------------------------------
  logic rx_rdy_q;
  logic rx_ovf_q;
  logic [3:0] dtmf_code_q;
  logic [7:0] dtmf_key_q;
  logic fsk_q;
  logic live;
  logic rdy_ev;
  logic ovf_ev;
  logic dtmf_ev;

  assign live = ~quiet & ~mode_chg;
  assign rdy_ev = live & modem_mode & RX_EVT.rx_ready;
  assign dtmf_ev = live & dtmf_mode & RX_EVT.dtmf_burst;
  assign ovf_ev = (live & modem_mode & RX_EVT.rx_overflow) | dtmf_ev;

  // set beats the read clear; mode change clears at once
  always_ff @(posedge CORE_CLK) begin
    if (RESET || quiet || mode_chg) begin
      rx_rdy_q <= 1'b0;
    end else if (rdy_ev) begin
      rx_rdy_q <= 1'b1;
    end else if (RXDATA_RD) begin
      rx_rdy_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || quiet || mode_chg) begin
      rx_ovf_q <= 1'b0;
    end else if (ovf_ev) begin
      rx_ovf_q <= 1'b1;
    end else if (RXDATA_RD) begin
      rx_ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || hold) begin
      dtmf_code_q <= 4'h0;
      dtmf_key_q <= 8'h00;
    end else if (dtmf_ev) begin
      dtmf_code_q <= RX_EVT.dtmf_code;
      dtmf_key_q <= msirq_dtmf_ascii(RX_EVT.dtmf_code);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || quiet || !fsk_mode) begin
      fsk_q <= 1'b0;
    end else if (RX_EVT.fsk_strobe) begin
      fsk_q <= RX_EVT.fsk_bit;
    end
  end

  // ---------------------------------------------------------------
  // automodem status word
  // ---------------------------------------------------------------
  logic [5:0] am_msg_q;
  logic [2:0] am_snr_q;
  logic [3:0] am_mode_q;
  logic am_evt_q;
  logic am_chg;

  assign am_chg = ~quiet & qam_mode &
                  (AM_IN.msg_upd | (AM_IN.signal_noise_grade != am_snr_q) | (AM_IN.mode != am_mode_q));

  always_ff @(posedge CORE_CLK) begin
    if (RESET || hold) begin
      am_msg_q <= AM_RESET[15:10];
      am_snr_q <= AM_RESET[6:4];
      am_mode_q <= AM_RESET[3:0];
    end else if (~quiet && qam_mode) begin
      if (AM_IN.msg_upd) begin
        am_msg_q <= AM_IN.msg;
      end
      am_snr_q <= AM_IN.signal_noise_grade;
      am_mode_q <= AM_IN.mode;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || hold) begin
      am_evt_q <= 1'b0;
    end else if (am_chg) begin
      am_evt_q <= 1'b1;
    end else if (AM_RD) begin
      am_evt_q <= 1'b0;
    end
  end

  // only meaningful while the programming flag is up; host keeps to that
  assign AM_STATUS_WORD = {am_msg_q, AM_ZERO_FIELD, am_snr_q, am_mode_q};

  // ---------------------------------------------------------------
  // interrupt bit and pin
  // ---------------------------------------------------------------
  logic irq_q;
  logic irq_set;
  logic ring_irq;

  assign ring_irq = ring_rise & GCR_WORD[GC_MASK_RING] & GCR_WORD[GC_IRQ_OE];
  assign irq_set = ring_irq |
                   (((rdy_ev & ~rx_rdy_q) | (ovf_ev & ~rx_ovf_q)) & GCR_WORD[GC_MASK_RX]) |
                   (am_chg & ~am_evt_q & GCR_WORD[GC_MASK_AM]);

  // setting a reset bit clears irq; a new event on the read beats the clear
  always_ff @(posedge CORE_CLK) begin
    if (RESET || hold_rise) begin
      irq_q <= 1'b0;
    end else if (irq_set) begin
      irq_q <= 1'b1;
    end else if (STATUS_RD) begin
      irq_q <= 1'b0;
    end
  end

  assign HOST_INTERRUPT_OE = irq_q & GCR_WORD[GC_IRQ_OE];
  assign HOST_INTERRUPT_OUT_LOW = ~HOST_INTERRUPT_OE;
  assign DTMF_KEY = dtmf_key_q;

  always_comb begin
    STATUS_WORD = ST_RESET;
    STATUS_WORD[ST_IRQ] = irq_q;
    STATUS_WORD[ST_RING] = ring_level;
    STATUS_WORD[ST_PROG] = PROG_FLAG;
    STATUS_WORD[ST_AM_EVT] = am_evt_q;
    STATUS_WORD[ST_RX_RDY] = rx_rdy_q;
    STATUS_WORD[ST_RX_OVF] = rx_ovf_q;
    if (dtmf_mode) begin
      STATUS_WORD[3:0] = dtmf_code_q;
    end else if (fsk_mode) begin
      STATUS_WORD[ST_FSK] = fsk_q;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic settle_pend_q;
  logic [15:0] settle_cnt_q;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      settle_pend_q <= 1'b0;
      settle_cnt_q <= 16'h0000;
    end else if (mode_chg) begin
      settle_pend_q <= 1'b1;
      settle_cnt_q <= 16'h0000;
    end else if (settle_pend_q) begin
      settle_pend_q <= rx_rdy_q | rx_ovf_q;
      settle_cnt_q <= settle_cnt_q + 16'h0001;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  sequence s_rx_event_masked;
    rdy_ev && !rx_rdy_q && GCR_WORD[GC_MASK_RX] && !hold_rise;
  endsequence

  sequence s_ring_armed;
    ring_rise && GCR_WORD[GC_MASK_RING] && GCR_WORD[GC_IRQ_OE] && !hold_rise;
  endsequence

  property p_irq_set;
    s_rx_event_masked |=> irq_q ##1 (irq_q || $past(STATUS_RD) || $past(hold_rise));
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("masked event did not raise irq");

  property p_irq_clr;
    irq_q && STATUS_RD && !irq_set |=> !irq_q;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("status read did not clear irq");

  property p_irq_pin;
    HOST_INTERRUPT_OUT_LOW == !(irq_q && GCR_WORD[GC_IRQ_OE]);
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin disagrees with irq");

  property p_rx_clr;
    rx_rdy_q && RXDATA_RD && !rdy_ev |=> !rx_rdy_q;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("data read did not clear ready");

  property p_settle;
    settle_pend_q |-> settle_cnt_q < 16'(SETTLE_CYC);
  endproperty
  a_settle: assert property (p_settle) else $error("mode change took too long");

  property p_ring_follow;
    (RING_SENSE_IN_LOW == $past(RING_SENSE_IN_LOW))[*4] |-> STATUS_WORD[ST_RING] == !RING_SENSE_IN_LOW;
  endproperty
  a_ring_follow: assert property (p_ring_follow) else $error("ring bit not inverse of pin");

  property p_ring_irq;
    s_ring_armed |=> irq_q;
  endproperty
  a_ring_irq: assert property (p_ring_irq) else $error("ring edge did not raise irq");

  property p_ring_gate;
    ring_rise && !GCR_WORD[GC_MASK_RING] && !irq_q && !(irq_set) |=> !irq_q;
  endproperty
  a_ring_gate: assert property (p_ring_gate) else $error("ring irq without enable");

  property p_fsk;
    live && fsk_mode && RX_EVT.fsk_strobe ##1 fsk_mode && !quiet |-> STATUS_WORD[ST_FSK] == $past(RX_EVT.fsk_bit);
  endproperty
  a_fsk: assert property (p_fsk) else $error("fsk bit not refreshed");

  property p_dtmf;
    dtmf_ev ##1 dtmf_mode && !hold |-> STATUS_WORD[ST_RX_OVF] && STATUS_WORD[3:0] == $past(RX_EVT.dtmf_code);
  endproperty
  a_dtmf: assert property (p_dtmf) else $error("dtmf burst not reported");

  property p_am_layout;
    AM_STATUS_WORD[9:7] == AM_ZERO_FIELD && AM_STATUS_WORD[15:10] == am_msg_q;
  endproperty
  a_am_layout: assert property (p_am_layout) else $error("automodem word layout wrong");

  property p_am_evt;
    am_chg && !hold |=> STATUS_WORD[ST_AM_EVT];
  endproperty
  a_am_evt: assert property (p_am_evt) else $error("automodem change did not set bit9");

  property p_am_clr;
    am_evt_q && AM_RD && !am_chg |=> !STATUS_WORD[ST_AM_EVT];
  endproperty
  a_am_clr: assert property (p_am_clr) else $error("automodem read did not clear bit9");
endmodule : msirq_status

/* File: common/msirq_pkg.sv */
// constants, carriers and code tables for the modem status and interrupt block
package msirq_pkg;

  // ---------------------------------------------------------------
  // status word bit positions
  // ---------------------------------------------------------------
  localparam int STAT_W = 16;
  localparam int ST_IRQ = 15;
  localparam int ST_RING = 14;
  localparam int ST_PROG = 13;
  localparam int ST_AM_EVT = 9;
  localparam int ST_RX_RDY = 6;
  localparam int ST_RX_OVF = 5;
  localparam int ST_FSK = 0;
  localparam logic [15:0] ST_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // general control word bit positions
  // ---------------------------------------------------------------
  localparam int GC_MASK_RX = 0;
  localparam int GC_MASK_AM = 1;
  localparam int GC_MASK_RING = 5;
  localparam int GC_IRQ_OE = 6;
  localparam int GC_RESET = 7;
  localparam int GC_GEN_RST = 8;

  // ---------------------------------------------------------------
  // automodem status word
  // ---------------------------------------------------------------
  localparam logic [7:0] AM_STATUS_ADDR = 8'heb;
  localparam int AM_MSG_LSB = 10;
  localparam int AM_SNR_LSB = 4;
  localparam logic [15:0] AM_RESET = 16'h0000;
  localparam logic [2:0] AM_ZERO_FIELD = 3'h0;
  // message upper-bit groups and full codes
  localparam logic [2:0] MSG_GRP_R5 = 3'h7;
  localparam logic [2:0] MSG_GRP_R4 = 3'h6;
  localparam logic [2:0] MSG_GRP_R3 = 3'h5;
  localparam logic [2:0] MSG_GRP_R2 = 3'h4;
  localparam logic [2:0] MSG_GRP_R1 = 3'h3;
  localparam logic [2:0] MSG_GRP_EVENT = 3'h2;
  localparam logic [5:0] MSG_RATE_NEG = 6'h17;
  localparam logic [5:0] MSG_RETRAIN_REQ = 6'h16;
  localparam logic [5:0] MSG_EMERG_RETRAIN = 6'h15;
  localparam logic [5:0] MSG_CARRIER_LOST = 6'h14;
  localparam logic [5:0] MSG_PREAMBLE = 6'h13;
  localparam logic [5:0] MSG_S1 = 6'h12;
  localparam logic [5:0] MSG_SB1 = 6'h11;
  localparam logic [5:0] MSG_USB1 = 6'h10;
  localparam logic [5:0] MSG_ANS_TONE = 6'h0f;
  // bit-rate codes carried in the low message bits
  localparam logic [2:0] RATE_14400 = 3'h7;
  localparam logic [2:0] RATE_12000 = 3'h6;
  localparam logic [2:0] RATE_9600_TCM = 3'h5;
  localparam logic [2:0] RATE_9600 = 3'h4;
  localparam logic [2:0] RATE_7200 = 3'h3;
  localparam logic [2:0] RATE_4800 = 3'h2;
  localparam logic [2:0] RATE_2400 = 3'h1;
  localparam logic [2:0] RATE_1200 = 3'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int MODE_SETTLE_US = 150;
  // longest time, in whole core clock cycles: 150 us at 100 MHz, exact
  localparam int MODE_SETTLE_CYC = MODE_SETTLE_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // modes and carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RXM_IDLE, RXM_FSK, RXM_QAM, RXM_DTMF} msirq_rxmode_t;

  typedef struct packed {
    logic rx_ready;
    logic rx_overflow;
    logic dtmf_burst;
    logic [3:0] dtmf_code;
    logic fsk_strobe;
    logic fsk_bit;
  } msirq_rx_evt_t;

  typedef struct packed {
    logic msg_upd;
    logic [5:0] msg;
    logic [2:0] signal_noise_grade;
    logic [3:0] mode;
  } msirq_am_t;

  // keypad symbol as ascii for a received tone-pair code
  function automatic logic [7:0] msirq_dtmf_ascii(input logic [3:0] code);
    logic [7:0] r;
    r = 8'h30;
    case (code)
      4'h0: r = 8'h44;
      4'ha: r = 8'h30;
      4'hb: r = 8'h2a;
      4'hc: r = 8'h23;
      4'hd: r = 8'h41;
      4'he: r = 8'h42;
      4'hf: r = 8'h43;
      default: r = 8'h30 + {4'h0, code};
    endcase
    return r;
  endfunction : msirq_dtmf_ascii

endpackage : msirq_pkg

/* File: hdl/msirq_ring_sense.sv */
// ring sense pin synchroniser and edge detector
module msirq_ring_sense (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, high
  input wire logic pin_low, // ring sense pin, low when ringing
  output logic ring_level, // inverted, synchronised pin level
  output logic ring_rise // one cycle on pin falling edge
);
  logic sync1_q;
  logic sync2_q;
  logic lvl_q;

  // pin idles high, so sync stages reset high to avoid a false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_low;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= ~sync2_q;
    end
  end

  assign ring_level = lvl_q;
  assign ring_rise = ~sync2_q & ~lvl_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_edge_level;
    ring_rise |=> ring_level;
  endproperty
  a_edge_level: assert property (p_edge_level) else $error("ring edge without level rise");
endmodule : msirq_ring_sense

/* File: testbench/msirq_host_model.sv */
// host controller model issuing one-cycle register read strobes
module msirq_host_model (
  input wire logic clk, // core clock
  input wire logic [15:0] status_word, // main status word seen by host
  output logic status_rd, // status word read strobe
  output logic rxdata_rd, // receive data read strobe
  output logic am_rd // automodem word read strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // read strobes
  // ---------------------------------------------------------------
  initial begin
    status_rd = 1'b0;
    rxdata_rd = 1'b0;
    am_rd = 1'b0;
  end

  // 0 status word, 1 receive data, 2 automodem word
  task automatic strobe(input int which);
    @(negedge clk);
    status_rd = (which == 0);
    rxdata_rd = (which == 1);
    am_rd = (which >= 2);
    @(negedge clk);
    status_rd = 1'b0;
    rxdata_rd = 1'b0;
    am_rd = 1'b0;
  endtask : strobe

  // word is only valid once the programming flag is up, so wait for it
  task automatic read_am(output logic ok);
    int n;
    n = 0;
    while (status_word[13] !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    ok = (status_word[13] === 1'b1);
    if (ok) begin
      strobe(2);
    end
  endtask : read_am
endmodule : msirq_host_model

/* File: testbench/modem_status_irq_reporting_tb_top.sv */
// self-checking testbench for the modem status and interrupt block
module modem_status_irq_reporting_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import msirq_pkg::*;

  logic core_clk, reset, powersave, prog_flag, ring_low, ok;
  logic status_rd, rxdata_rd, am_rd, irq_low, irq_oe;
  logic [15:0] gcr, stat, am_word;
  logic [7:0] key;
  logic [5:0] m;
  msirq_rxmode_t rx_mode;
  msirq_rx_evt_t rx_evt;
  msirq_am_t am_in;
  int errors, num_checks, cycles;
  localparam string KEYS = "D1234567890*#ABC";

  msirq_status #(.SETTLE_CYC(100)) dut (
    .CORE_CLK(core_clk), .RESET(reset), .GCR_WORD(gcr), .POWERSAVE(powersave),
    .RX_MODE(rx_mode), .PROG_FLAG(prog_flag), .RX_EVT(rx_evt), .AM_IN(am_in),
    .STATUS_RD(status_rd), .RXDATA_RD(rxdata_rd), .AM_RD(am_rd),
    .RING_SENSE_IN_LOW(ring_low), .STATUS_WORD(stat), .AM_STATUS_WORD(am_word),
    .DTMF_KEY(key), .HOST_INTERRUPT_OUT_LOW(irq_low), .HOST_INTERRUPT_OE(irq_oe)
  );

  msirq_host_model host (
    .clk(core_clk), .status_word(stat), .status_rd(status_rd), .rxdata_rd(rxdata_rd), .am_rd(am_rd)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  // one-cycle receive event, fields in struct order
  task automatic ev(input logic rdy, ovf, bst, input logic [3:0] code, input logic stb, bv);
    rx_evt = '{rdy, ovf, bst, code, stb, bv};
    tick(1);
    rx_evt = '0;
  endtask : ev

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_rx();
    gcr = 16'h0041;
    rx_mode = RXM_FSK;
    tick(2);
    ev(1, 0, 0, 0, 0, 0);
    chk(stat & 16'h8040, 16'h8040);
    chk({14'h0, irq_oe, irq_low}, 16'h0002);
    host.strobe(1);
    chk(stat & 16'h8040, 16'h8000);
    host.strobe(0);
    chk(stat & 16'h8040, 16'h0000);
    chk({14'h0, irq_oe, irq_low}, 16'h0001);
    gcr = 16'h0040;
    ev(0, 1, 0, 0, 0, 0);
    chk(stat & 16'h8020, 16'h0020);
    chk({14'h0, irq_oe, irq_low}, 16'h0001);
    host.strobe(1);
    chk(stat & 16'h0020, 16'h0000);
    ev(0, 0, 0, 0, 1, 1);
    chk({15'h0, stat[0]}, 16'h0001);
    tick(1);
    ev(0, 0, 0, 0, 1, 0);
    chk({15'h0, stat[0]}, 16'h0000);
    tick(1);
    ev(1, 0, 0, 0, 0, 0);
    rx_mode = RXM_DTMF;
    tick(2);
    chk(stat & 16'h0040, 16'h0000);
    $display("test rx done");
  endtask : t_rx

  task automatic t_dtmf();
    gcr = 16'h0001;
    tick(2);
    for (int c = 0; c < 16; c++) begin
      ev(0, 0, 1, 4'(c), 0, 0);
      chk(stat & 16'h802f, 16'h8020 | 16'(c));
      chk({8'h0, key}, {8'h0, KEYS[c]});
      host.strobe(1);
      host.strobe(0);
    end
    $display("test dtmf done");
  endtask : t_dtmf

  task automatic t_ring();
    gcr = 16'h00e0;
    powersave = 1'b1;
    tick(2);
    ring_low = 1'b0;
    tick(4);
    chk(stat & 16'hc000, 16'hc000);
    chk({14'h0, irq_oe, irq_low}, 16'h0002);
    gcr = 16'h0060;
    tick(2);
    host.strobe(0);
    chk(stat & 16'hc000, 16'h4000);
    ring_low = 1'b1;
    tick(4);
    chk(stat & 16'hc000, 16'h0000);
    gcr = 16'h0040;
    ring_low = 1'b0;
    tick(4);
    chk(stat & 16'hc000, 16'h4000);
    ring_low = 1'b1;
    powersave = 1'b0;
    tick(4);
    $display("test ring done");
  endtask : t_ring

  task automatic t_am();
    gcr = 16'h0002;
    rx_mode = RXM_QAM;
    prog_flag = 1'b1;
    tick(2);
    for (int i = 0; i < 17; i++) begin
      if (i < 8) m = {3'(3 + i % 5), 3'(i)};
      else if (i < 16) m = 6'h10 + 6'(i - 8);
      else m = 6'h0f;
      am_in = '{1'b1, m, 3'(i), 4'(i)};
      tick(1);
      am_in.msg_upd = 1'b0;
      chk(am_word, {m, 3'b000, 3'(i), 4'(i)});
      chk(stat & 16'h8200, 16'h8200);
      host.read_am(ok);
      chk({15'h0, ok}, 16'h0001);
      chk(stat & 16'h0200, 16'h0000);
      host.strobe(0);
    end
    am_in.signal_noise_grade = 3'h6;
    tick(2);
    chk(stat & 16'ha200, 16'ha200);
    chk(am_word & 16'h0070, 16'h0060);
    host.read_am(ok);
    chk(stat & 16'h0200, 16'h0000);
    // general reset bit rising clears a pending irq
    gcr = 16'h0102;
    tick(2);
    chk(stat & 16'h8000, 16'h0000);
    $display("test automodem done");
  endtask : t_am

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    errors = 0;
    num_checks = 0;
    cycles = 0;
    reset = 1'b1;
    gcr = 16'h0000;
    powersave = 1'b0;
    prog_flag = 1'b0;
    ring_low = 1'b1;
    rx_mode = RXM_IDLE;
    rx_evt = '0;
    am_in = '0;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    tick(1);
    chk(stat, 16'h0000);
    chk({14'h0, irq_oe, irq_low}, 16'h0001);
    t_rx();
    t_dtmf();
    t_ring();
    t_am();
    close_out();
  end
endmodule : modem_status_irq_reporting_tb_top
